// *** verilog/ssc_pkg.sv ***
// Purpose: shared constants and types for the static space configuration
// Assumes: 32-bit register bus, one system clock
// Notes: the config struct layout is the register bit layout
package ssc_pkg;

  // register byte offsets on the register bus
  localparam logic [7:0] SSC_OFS_CONFIG = 8'h00;
  localparam logic [7:0] SSC_OFS_STATUS = 8'h04;
  localparam int SSC_ADDR_W = 8;

  // space configuration reset value and writable bits
  localparam logic [31:0] SSC_CFG_RESET = 32'h01fc3faf;
  localparam logic [31:0] SSC_CFG_WMASK = 32'h03ff3fbf;

  // field positions of the space configuration word
  localparam int SSC_POS_SRAM_PAR = 25;
  localparam int SSC_POS_SRAM_GAP = 24;
  localparam int SSC_POS_SRAM_RW = 21;
  localparam int SSC_POS_SRAM_WW = 18;
  localparam int SSC_POS_SRAM_SZ = 16;
  localparam int SSC_POS_ROM_PAR = 14;
  localparam int SSC_POS_ROM_GAP = 13;
  localparam int SSC_POS_ROM_RW = 10;
  localparam int SSC_POS_ROM_SZ = 8;
  localparam int SSC_POS_GEN_DS = 7;
  localparam int SSC_POS_GEN_PAR = 6;
  localparam int SSC_POS_GEN_GAP = 5;
  localparam int SSC_POS_GEN_UNIT = 4;
  localparam int SSC_POS_GEN_WT = 2;
  localparam int SSC_POS_GEN_SZ = 0;

  // width code meaning "space absent"
  localparam logic [1:0] SSC_WIDTH_NONE = 2'h0;

  // access length in clocks per wait code 0..7, four bits per code
  localparam logic [31:0] SSC_LEN_TAB = 32'hca865432;
  // general device length is this base plus the wait code, in units
  localparam logic [3:0] SSC_GEN_LEN_BASE = 4'h4;

  // top address bits selecting each space
  localparam logic [3:0] SSC_ROM_TOP = 4'h0;
  localparam logic [3:0] SSC_SRAM_TOP = 4'h1;
  localparam logic [1:0] SSC_GEN_TOP = 2'h1;

  // bus responses
  localparam logic [1:0] SSC_RESP_OKAY = 2'h0;
  localparam logic [1:0] SSC_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [5:0] rsv_hi;
    logic sram_parity_enable;
    logic sram_idle_gap_enable;
    logic [2:0] sram_read_wait_sel;
    logic [2:0] sram_write_wait_sel;
    logic [1:0] sram_width_sel;
    logic rsv_mid;
    logic rom_parity_enable;
    logic rom_idle_gap_enable;
    logic [2:0] rom_read_wait_sel;
    logic [1:0] rom_width_sel;
    logic gen_write_setup_guarantee;
    logic gen_parity_enable;
    logic gen_idle_gap_enable;
    logic gen_clock_unit_sel;
    logic [1:0] gen_wait_sel;
    logic [1:0] gen_width_sel;
  } ssc_cfg_t;

  typedef enum logic [1:0] {
    SSC_SP_NONE = 2'h0,
    SSC_SP_ROM = 2'h1,
    SSC_SP_SRAM = 2'h2,
    SSC_SP_GEN = 2'h3
  } ssc_space_t;

  // core request and answer
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic write;
    logic fetch;
  } ssc_req_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic instr_exc;
    logic data_exc;
    logic bus_err;
  } ssc_rsp_t;

endpackage

// *** verilog/ssc_access_timer.sv ***
// Purpose: counts the length of one external access in time units
// Assumes: start is a one-cycle pulse in the cycle before the access
// Notes: a unit is one clock, or two clocks when unit_two is set
module ssc_access_timer
  import ssc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [3:0] len,
  input wire logic unit_two,
  output logic done
);

  logic [3:0] remain;
  logic active;
  logic two_q;
  logic phase;
  logic unit_tick;

  // divider enable: every clock, or every second clock
  assign unit_tick = active && (!two_q || phase);
  assign done = unit_tick && (remain == 4'h1);

  // unit counter and divider phase
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      remain <= 4'h0;
      active <= 1'b0;
      two_q <= 1'b0;
      phase <= 1'b0;
    end else if (start) begin
      remain <= len;
      active <= 1'b1;
      two_q <= unit_two;
      phase <= 1'b0;
    end else if (active) begin
      phase <= two_q ? !phase : 1'b0;
      if (unit_tick) begin
        remain <= remain - 4'h1;
        active <= (remain != 4'h1);
      end
    end
  end

endmodule // ssc_access_timer

// *** verilog/ssc_space_ctrl.sv ***
// Purpose: space configuration register and access shaping for ROM,
//   SRAM and general device spaces
// Assumes: AXI4-Lite register port, one access at a time from the core
// Notes: external inputs pass a two-stage synchroniser before use
//
// Operation
// - SRAM parity check resets off; when on, parity error gives bus error
// - SRAM idle gap resets on; one idle clock after ROM or DRAM read
// - SRAM read wait code resets 111; lengths 2,3,4,5,6,8,10,12 clocks
// - SRAM write wait code resets 111; same length table for writes
// - SRAM width resets 00; 00 absent, then 8, 16, 32 bits
// - SRAM width 00 makes SRAM access raise fetch or data exception
// - ROM parity check resets off and stays off in this device
// - ROM idle gap resets on; one idle clock after SRAM or DRAM read
// - ROM read wait code resets 111; lengths 2,3,4,5,6,8,10,12 clocks
// - ROM width code selects none, 8, 16 or 32 bit ROM access
// - ROM width 00 makes ROM access raise exception, no external cycle
// - general write setup resets on; data driven before write strobe
// - general parity check resets off and stays off in this device
// - general idle gap resets on; one idle clock after SRAM or DRAM read
// - general clock unit resets to one clock; set selects two clocks
// - general wait code resets 11; lengths 4 to 7 time units
// - general width resets 11; 00 absent, then 8, 16, 32 bits
// - general width 00 makes access raise exception, no bus cycle
// - ROM space decodes to ROM accesses with low ROM select
// - 0x1000_0000 to 0x1fff_ffff decodes to SRAM with low SRAM select
// - general space decodes to peripheral access with low address strobe
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
module ssc_space_ctrl
  import ssc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  // register bus
  input wire logic [SSC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [SSC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // core request and answer
  input wire logic cpu_req_valid,
  input wire ssc_req_t cpu_req,
  output logic cpu_req_ready,
  output logic cpu_rsp_valid,
  output ssc_rsp_t cpu_rsp,
  // external memory and device side
  output logic [31:0] ext_addr,
  output logic [31:0] ext_wdata,
  output logic ext_wdata_oe,
  input wire logic [31:0] ext_rdata,
  input wire logic ext_parity_err,
  output logic [1:0] ext_width,
  output logic rom_sel_n,
  output logic sram_sel_n,
  output logic addr_strobe_n,
  output logic rd_strobe_n,
  output logic wr_strobe_n
);

  typedef enum logic [2:0] {
    SSC_ST_IDLE = 3'b000,
    SSC_ST_GAP = 3'b001,
    SSC_ST_SETUP = 3'b011,
    SSC_ST_ACCESS = 3'b010
  } ssc_state_t;

  ssc_state_t state;
  ssc_state_t next_state;
  logic [31:0] space_config;
  ssc_cfg_t cfg;

  // ---------------- register bus slave ----------------
  logic aw_held;
  logic w_held;
  logic [SSC_ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_fire;
  logic wr_hit_cfg;
  logic wr_hit_stat;
  logic rd_fire;
  logic rd_hit_cfg;
  logic rd_hit_stat;
  logic [31:0] byte_mask;
  logic [31:0] status_word;
  logic last_instr_exc;
  logic last_data_exc;
  logic last_bus_err;

  assign cfg = ssc_cfg_t'(space_config);

  // address and data accepted independently, held until the response
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_hit_cfg = (aw_addr_q == SSC_OFS_CONFIG);
  assign wr_hit_stat = (aw_addr_q == SSC_OFS_STATUS);
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_hit_cfg = (s_axi_araddr == SSC_OFS_CONFIG);
  assign rd_hit_stat = (s_axi_araddr == SSC_OFS_STATUS);

  // byte enables widened to bit mask, limited to writable bits
  generate
    for (genvar b = 0; b < 4; b++) begin : g_lane
      assign byte_mask[b*8 +: 8] = {8{w_strb_q[b]}} & SSC_CFG_WMASK[b*8 +: 8];
    end
  endgenerate

  // status word: busy and the flags of the last answer
  assign status_word = {28'h0000000, last_bus_err, last_data_exc,
                        last_instr_exc, (state != SSC_ST_IDLE)};

  // write channel holding registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // write response; status is read-only, unmapped addresses are refused
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SSC_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit_cfg ? SSC_RESP_OKAY : SSC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // space configuration register; parity bits of ROM and general space
  // are masked out of the writable set and always read zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      space_config <= SSC_CFG_RESET;
    end else if (wr_fire && wr_hit_cfg) begin
      space_config <= (space_config & ~byte_mask) |
                      (w_data_q & byte_mask);
    end
  end

  // read channel
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= SSC_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_hit_cfg ? space_config :
                     (rd_hit_stat ? status_word : 32'h00000000);
      s_axi_rresp <= (rd_hit_cfg || rd_hit_stat) ? SSC_RESP_OKAY
                                                 : SSC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- external input synchronisers ----------------
  logic [32:0] ext_meta;
  logic [32:0] ext_sync;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_meta <= '0;
      ext_sync <= '0;
    end else begin
      ext_meta <= {ext_parity_err, ext_rdata};
      ext_sync <= ext_meta;
    end
  end

  // ---------------- request decode ----------------
  ssc_space_t req_space;
  logic [1:0] req_width;
  logic req_invalid;
  logic [2:0] req_wait_code;
  logic [3:0] req_len;
  logic req_setup;
  logic req_gap;
  logic tmr_done;
  logic accept;
  logic last_cycle;
  logic [2:0] pend; // answer waits for synced data: par, rd, valid

  // top address bits pick the space
  assign req_space =
    (cpu_req.addr[31:28] == SSC_ROM_TOP) ? SSC_SP_ROM :
    (cpu_req.addr[31:28] == SSC_SRAM_TOP) ? SSC_SP_SRAM :
    (cpu_req.addr[31:30] == SSC_GEN_TOP) ? SSC_SP_GEN :
    SSC_SP_NONE;

  assign req_width =
    (req_space == SSC_SP_ROM) ? cfg.rom_width_sel :
    (req_space == SSC_SP_SRAM) ? cfg.sram_width_sel :
    (req_space == SSC_SP_GEN) ? cfg.gen_width_sel :
    SSC_WIDTH_NONE;

  // absent width or a space not served here gives an exception
  assign req_invalid = (req_width == SSC_WIDTH_NONE);

  assign req_wait_code =
    (req_space == SSC_SP_ROM) ? cfg.rom_read_wait_sel :
    (req_space == SSC_SP_GEN) ? {1'b0, cfg.gen_wait_sel} :
    cpu_req.write ? cfg.sram_write_wait_sel
                  : cfg.sram_read_wait_sel;

  // length in time units; general space counts base plus code
  assign req_len = (req_space == SSC_SP_GEN) ?
                   SSC_GEN_LEN_BASE + {2'b00, cfg.gen_wait_sel} :
                   SSC_LEN_TAB[{req_wait_code, 2'b00} +: 4];

  // write data ahead of the strobe for general space writes
  assign req_setup = (req_space == SSC_SP_GEN) && cpu_req.write &&
                     cfg.gen_write_setup_guarantee;

  // an idle clock is needed only when the new access would abut a read
  // of a conflicting space; DRAM reads never end inside this block
  logic cur_write;
  ssc_space_t cur_space;
  assign req_gap = last_cycle && !cur_write && (
    ((req_space == SSC_SP_SRAM) && (cur_space == SSC_SP_ROM) &&
     cfg.sram_idle_gap_enable) ||
    ((req_space == SSC_SP_ROM) && (cur_space == SSC_SP_SRAM) &&
     cfg.rom_idle_gap_enable) ||
    ((req_space == SSC_SP_GEN) && (cur_space == SSC_SP_SRAM) &&
     cfg.gen_idle_gap_enable));

  assign last_cycle = (state == SSC_ST_ACCESS) && tmr_done;
  // a refusal in idle would collide with the delayed answer
  assign cpu_req_ready = last_cycle ||
    ((state == SSC_ST_IDLE) && !(pend[0] && req_invalid));
  assign accept = cpu_req_valid && cpu_req_ready;

  // ---------------- access sequencer ----------------
  logic cur_setup;
  logic cur_fetch;
  logic cur_unit_two;
  logic [3:0] cur_len;
  logic tmr_start;
  logic [3:0] tmr_len;
  logic parity_on;

  always_comb begin
    next_state = state;
    case (state)
      SSC_ST_IDLE: begin
        if (accept && !req_invalid) begin
          next_state = req_setup ? SSC_ST_SETUP : SSC_ST_ACCESS;
        end
      end
      SSC_ST_GAP: begin
        next_state = cur_setup ? SSC_ST_SETUP : SSC_ST_ACCESS;
      end
      SSC_ST_SETUP: begin
        next_state = SSC_ST_ACCESS;
      end
      SSC_ST_ACCESS: begin
        if (tmr_done) begin
          if (accept && !req_invalid) begin
            next_state = req_gap ? SSC_ST_GAP :
                         (req_setup ? SSC_ST_SETUP : SSC_ST_ACCESS);
          end else begin
            next_state = SSC_ST_IDLE;
          end
        end
      end
      default: begin
        next_state = SSC_ST_IDLE;
      end
    endcase
  end

  // timer starts on every entry into the access state
  assign tmr_start = (next_state == SSC_ST_ACCESS) &&
                     ((state != SSC_ST_ACCESS) || tmr_done);
  assign tmr_len = accept ? req_len : cur_len;

  ssc_access_timer u_timer (
    .clk(clk),
    .reset_n(reset_n),
    .start(tmr_start),
    .len(tmr_len),
    .unit_two(accept ? ((req_space == SSC_SP_GEN) &&
                        cfg.gen_clock_unit_sel) : cur_unit_two),
    .done(tmr_done)
  );

  // state and the latched access
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= SSC_ST_IDLE;
      cur_space <= SSC_SP_NONE;
      cur_write <= 1'b0;
      cur_fetch <= 1'b0;
      cur_setup <= 1'b0;
      cur_unit_two <= 1'b0;
      cur_len <= 4'h0;
      ext_addr <= 32'h00000000;
      ext_wdata <= 32'h00000000;
      ext_width <= 2'h0;
    end else begin
      state <= next_state;
      if (accept && !req_invalid) begin
        cur_space <= req_space;
        cur_write <= cpu_req.write;
        cur_fetch <= cpu_req.fetch;
        cur_setup <= req_setup;
        cur_unit_two <= (req_space == SSC_SP_GEN) &&
                        cfg.gen_clock_unit_sel;
        cur_len <= req_len;
        ext_addr <= cpu_req.addr;
        ext_wdata <= cpu_req.wdata;
        ext_width <= req_width;
      end
    end
  end

  // parity checking per space; ROM and general bits are held at zero
  assign parity_on =
    ((cur_space == SSC_SP_SRAM) && cfg.sram_parity_enable) ||
    ((cur_space == SSC_SP_ROM) && cfg.rom_parity_enable) ||
    ((cur_space == SSC_SP_GEN) && cfg.gen_parity_enable);

  // answer two cycles after the last access clock, one cycle after a refusal
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_rsp_valid <= 1'b0;
      cpu_rsp <= '0;
      last_instr_exc <= 1'b0;
      last_data_exc <= 1'b0;
      last_bus_err <= 1'b0;
      pend <= 3'h0;
    end else begin
      cpu_rsp_valid <= 1'b0;
      pend <= {parity_on && !cur_write, !cur_write, last_cycle};
      if (pend[0]) begin
        cpu_rsp_valid <= 1'b1;
        cpu_rsp.rdata <= pend[1] ? ext_sync[31:0] : 32'h00000000;
        cpu_rsp.instr_exc <= 1'b0;
        cpu_rsp.data_exc <= 1'b0;
        cpu_rsp.bus_err <= pend[2] && ext_sync[32];
        last_instr_exc <= 1'b0;
        last_data_exc <= 1'b0;
        last_bus_err <= pend[2] && ext_sync[32];
      end
      if (accept && req_invalid) begin
        cpu_rsp_valid <= 1'b1;
        cpu_rsp.rdata <= 32'h00000000;
        cpu_rsp.instr_exc <= cpu_req.fetch;
        cpu_rsp.data_exc <= !cpu_req.fetch;
        cpu_rsp.bus_err <= 1'b0;
        last_instr_exc <= cpu_req.fetch;
        last_data_exc <= !cpu_req.fetch;
        last_bus_err <= 1'b0;
      end
    end
  end

  // ---------------- external strobes ----------------
  logic on_bus;
  assign on_bus = (state == SSC_ST_SETUP) || (state == SSC_ST_ACCESS);
  assign rom_sel_n = !(on_bus && (cur_space == SSC_SP_ROM));
  assign sram_sel_n = !(on_bus && (cur_space == SSC_SP_SRAM));
  assign addr_strobe_n = !(on_bus && (cur_space == SSC_SP_GEN));
  assign rd_strobe_n = !((state == SSC_ST_ACCESS) && !cur_write);
  assign wr_strobe_n = !((state == SSC_ST_ACCESS) && cur_write);
  assign ext_wdata_oe = on_bus && cur_write;

endmodule // ssc_space_ctrl

// *** dv/ssc_ext_model.sv ***
// Purpose: external ROM, SRAM and peripheral data source
// Assumes: data is driven only while the read strobe is low
// Notes: a released bus shows a pattern that changes every clock
module ssc_ext_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [31:0] ext_addr,
  input wire logic rd_strobe_n,
  input wire logic bad_par,
  output logic [31:0] ext_rdata,
  output logic ext_parity_err
);
  logic [31:0] noise;
  // floating bus pattern while nobody drives
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) noise <= 32'h0;
    else noise <= noise + 32'h9e3779b9;
  end
  // read data follows the address, parity fault on command
  assign ext_rdata = rd_strobe_n ? noise : ext_addr ^ 32'h5a5a5a5a;
  assign ext_parity_err = bad_par && !rd_strobe_n;
endmodule // ssc_ext_model

// *** dv/ssc_space_ctrl_checker.sv ***
// Purpose: port-level checks of external access shaping
// Assumes: sees only top-level ports, one clock domain
// Notes: bound from the testbench top file
module ssc_space_ctrl_checker
  import ssc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic rd_strobe_n,
  input wire logic wr_strobe_n,
  input wire logic rom_sel_n,
  input wire logic sram_sel_n,
  input wire logic addr_strobe_n,
  input wire logic [31:0] ext_addr,
  input wire logic ext_wdata_oe,
  input wire logic cpu_rsp_valid
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [4:0] rd_len;
  wire any_sel = !rom_sel_n || !sram_sel_n || !addr_strobe_n;
  wire mem_rd = !rd_strobe_n && addr_strobe_n;
  // read strobe clocks of one ROM or SRAM access
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) rd_len <= 5'h0;
    else if (!mem_rd) rd_len <= 5'h0;
    else if (cpu_rsp_valid) rd_len <= 5'h1;
    else rd_len <= rd_len + 5'h1;
  end
  sequence s_rd_open;
    $fell(rd_strobe_n);
  endsequence
  sequence s_rd_close;
    $rose(rd_strobe_n);
  endsequence
  a_strobe_in_sel: assert property (
    !rd_strobe_n || !wr_strobe_n |-> any_sel)
    else $error("strobe outside any select");
  a_one_space: assert property (
    $onehot0({!rom_sel_n, !sram_sel_n, !addr_strobe_n}))
    else $error("two spaces selected");
  a_rom_decode: assert property (
    !rom_sel_n |-> ext_addr[31:28] == 4'h0)
    else $error("rom select outside rom space");
  a_sram_decode: assert property (
    !sram_sel_n |-> ext_addr[31:28] == 4'h1)
    else $error("sram select outside sram space");
  a_gen_decode: assert property (
    !addr_strobe_n |-> ext_addr[31:30] == 2'h1)
    else $error("address strobe outside device space");
  a_wr_data_on: assert property (
    !wr_strobe_n |-> ext_wdata_oe)
    else $error("write strobe without data driven");
  a_min_read: assert property (s_rd_open |=> !rd_strobe_n)
    else $error("read shorter than two clocks");
  a_max_read: assert property (rd_len <= 5'h0c)
    else $error("read longer than twelve clocks");
  a_rsp_at_end: assert property (s_rd_close |=> cpu_rsp_valid)
    else $error("no answer after read");
endmodule // ssc_space_ctrl_checker

// *** dv/tb.sv ***
// Purpose: self-checking bench of the space configuration block
// Assumes: register bus master and core requester live here
// Notes: access lengths are counted from the strobe pins
module tb
  import ssc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, reset_n = 1'h0, bad_par = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, cpu_req_valid = 1'h0;
  ssc_req_t cpu_req = '0;
  ssc_rsp_t cpu_rsp, rsp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, cpu_req_ready, cpu_rsp_valid, ext_wdata_oe;
  logic ext_parity_err, rom_sel_n, sram_sel_n, addr_strobe_n;
  logic rd_strobe_n, wr_strobe_n;
  logic [1:0] s_axi_bresp, s_axi_rresp, ext_width, resp;
  logic [31:0] s_axi_rdata, ext_addr, ext_wdata, ext_rdata, rd;
  int n_mismatch = 0, n_checks = 0, n_strb, n_sel, cyc = 0;
  int len_tab[8] = '{2, 3, 4, 5, 6, 8, 10, 12};
  ssc_cfg_t c;

  // 125 MHz system clock
  always #4 clk = ~clk;

  ssc_space_ctrl DUT (.clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_req_valid,
    .cpu_req, .cpu_req_ready, .cpu_rsp_valid, .cpu_rsp, .ext_addr,
    .ext_wdata, .ext_wdata_oe, .ext_rdata, .ext_parity_err, .ext_width,
    .rom_sel_n, .sram_sel_n, .addr_strobe_n, .rd_strobe_n, .wr_strobe_n);

  ssc_ext_model ext (.clk, .reset_n, .ext_addr, .rd_strobe_n, .bad_par,
    .ext_rdata, .ext_parity_err);

  task automatic bad(input string m);
    n_mismatch++;
    $display("wrong value at %0t: %s", $time, m);
  endtask
  task automatic chk_word(input logic [31:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) bad(m);
  endtask
  task automatic chk_cnt(input int got, exp, input string m);
    n_checks++;
    if (got != exp) bad(m);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // register bus write, address and data offered together
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok, b_ok;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(negedge clk);
      aw_ok = s_axi_awvalid && s_axi_awready;
      w_ok = s_axi_wvalid && s_axi_wready;
      b_ok = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge clk);
      if (aw_ok) s_axi_awvalid <= 1'h0;
      if (w_ok) s_axi_wvalid <= 1'h0;
    end while (!b_ok);
    s_axi_bready <= 1'h0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    logic ar_ok, r_ok;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(negedge clk);
      ar_ok = s_axi_arvalid && s_axi_arready;
      r_ok = s_axi_rvalid;
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clk);
      if (ar_ok) s_axi_arvalid <= 1'h0;
    end while (!r_ok);
    s_axi_rready <= 1'h0;
  endtask
  task automatic set_cfg(input ssc_cfg_t v);
    axi_wr(SSC_OFS_CONFIG, v);
    chk_word(resp, SSC_RESP_OKAY, "config write response");
  endtask

  // one core access; counts strobe and select clocks until the answer
  task automatic access(input logic [31:0] a, input logic wr, fe);
    logic ok;
    @(posedge clk);
    cpu_req <= '{addr: a, wdata: ~a, write: wr, fetch: fe};
    cpu_req_valid <= 1'h1;
    do begin
      @(negedge clk);
      ok = cpu_req_ready;
      @(posedge clk);
    end while (!ok);
    cpu_req_valid <= 1'h0;
    n_strb = 0;
    n_sel = 0;
    do begin
      @(negedge clk);
      if (!rd_strobe_n || !wr_strobe_n) n_strb++;
      if (!rom_sel_n || !sram_sel_n || !addr_strobe_n) n_sel++;
    end while (!cpu_rsp_valid);
    rsp = cpu_rsp;
  endtask

  task automatic t_regs;
    axi_rd(SSC_OFS_CONFIG);
    chk_word(rd, 32'h01fc3faf, "config reset value");
    axi_wr(SSC_OFS_CONFIG, 32'hffffffff);
    axi_rd(SSC_OFS_CONFIG);
    chk_word(rd, 32'h03ff3fbf, "config fixed bits");
    axi_rd(8'h40);
    chk_word(resp, SSC_RESP_SLVERR, "unmapped read response");
    chk_word(rd, 32'h0, "unmapped read data");
    set_cfg(32'h01fc3faf);
    $display("test registers done");
  endtask

  task automatic t_absent;
    access(32'h10000040, 1'h0, 1'h0);
    chk_word(rsp.data_exc, 1'h1, "sram load exception");
    chk_cnt(n_sel, 0, "sram cycle while absent");
    access(32'h10000044, 1'h0, 1'h1);
    chk_word(rsp.instr_exc, 1'h1, "sram fetch exception");
    c = 32'h01fc3faf;
    c.rom_width_sel = 2'h0;
    c.gen_width_sel = 2'h0;
    set_cfg(c);
    access(32'h00000100, 1'h0, 1'h1);
    chk_word(rsp.instr_exc, 1'h1, "rom fetch exception");
    chk_cnt(n_sel, 0, "rom cycle while absent");
    access(32'h40000000, 1'h1, 1'h0);
    chk_word(rsp.data_exc, 1'h1, "device store exception");
    chk_cnt(n_sel, 0, "device cycle while absent");
    $display("test absent spaces done");
  endtask

  task automatic t_rom;
    logic [31:0] a;
    for (int k = 0; k < 8; k++) begin
      c = 32'h01fc3faf;
      c.rom_read_wait_sel = k[2:0];
      c.rom_width_sel = 2'(k % 3 + 1);
      set_cfg(c);
      a = 32'h00001000 | 32'(k << 4);
      access(a, 1'h0, 1'h0);
      chk_cnt(n_strb, len_tab[k], "rom read length");
      chk_word(rsp.rdata, a ^ 32'h5a5a5a5a, "rom read data");
      chk_word(ext_width, c.rom_width_sel, "rom width");
    end
    $display("test rom waits done");
  endtask

  task automatic t_sram;
    c = 32'h01fc3faf;
    c.sram_width_sel = 2'h2;
    c.sram_read_wait_sel = 3'h4;
    c.sram_write_wait_sel = 3'h1;
    set_cfg(c);
    bad_par <= 1'h1;
    access(32'h1ffffff0, 1'h0, 1'h0);
    chk_cnt(n_strb, 6, "sram read length");
    chk_word(rsp.bus_err, 1'h0, "parity error ignored");
    chk_word(rsp.rdata, 32'h1ffffff0 ^ 32'h5a5a5a5a, "sram data");
    chk_word(ext_width, 2'h2, "sram width");
    access(32'h10000008, 1'h1, 1'h0);
    chk_cnt(n_strb, 3, "sram write length");
    c.sram_parity_enable = 1'h1;
    c.sram_read_wait_sel = 3'h7;
    set_cfg(c);
    access(32'h10000010, 1'h0, 1'h0);
    chk_word(rsp.bus_err, 1'h1, "parity error reported");
    chk_cnt(n_strb, 12, "sram longest read");
    bad_par <= 1'h0;
    $display("test sram done");
  endtask

  task automatic t_gen;
    c = 32'h01fc3faf;
    c.gen_clock_unit_sel = 1'h1;
    c.gen_wait_sel = 2'h2;
    set_cfg(c);
    access(32'h40000100, 1'h1, 1'h0);
    chk_cnt(n_strb, 12, "two clock units");
    chk_cnt(n_sel, 13, "setup clock before strobe");
    chk_word(ext_wdata, ~32'h40000100, "device write data");
    c.gen_clock_unit_sel = 1'h0;
    c.gen_wait_sel = 2'h0;
    set_cfg(c);
    access(32'h7ffffffc, 1'h0, 1'h0);
    chk_cnt(n_strb, 4, "shortest device read");
    chk_cnt(n_sel, 4, "one clock unit");
    $display("test general device done");
  endtask

  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test;
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'h1;
    t_regs;
    t_absent;
    t_rom;
    t_sram;
    t_gen;
    stop_test;
  end
endmodule // tb

bind ssc_space_ctrl ssc_space_ctrl_checker chk (.clk, .reset_n,
  .rd_strobe_n, .wr_strobe_n, .rom_sel_n, .sram_sel_n, .addr_strobe_n,
  .ext_addr, .ext_wdata_oe, .cpu_rsp_valid);
